// >>> rtl/sif_regs.svh
// Purpose: offsets, field positions and reset values of the stage flag words
// Assumes: 16-bit register words, word addressing
// Notes: definitions only
`ifndef SIF_REGS_SVH
`define SIF_REGS_SVH
`define SIF_ADDR_W 10
`define SIF_DONE_EN_OFS 10'h007
`define SIF_LOW_FLAGS_OFS 10'h008
`define SIF_HIGH_FLAGS_OFS 10'h009
`define SIF_DONE_FLAGS_OFS 10'h00a
`define SIF_STAGES 12
`define SIF_GPIO_BIT 12
`define SIF_FLAGS_RST 16'h0000
`define SIF_EN_RST 13'h0000
`endif

// >>> rtl/sif_pkg.sv
// Purpose: shared types of the stage flag block
// Assumes: twelve stages plus the general-purpose pin
// Notes: constants live in sif_regs.svh
`default_nettype none
package sif_pkg;
	typedef logic [15:0] sif_word_type;
	typedef logic [11:0] sif_stage_type;
endpackage : sif_pkg
`default_nettype wire

// >>> rtl/sif_stage_flags.sv
// Purpose: read-clear stage limit/done flags, pin change flag, interrupt output
// Assumes: serial port decoded elsewhere; read strobe is one cycle per word read
// Notes: read data is registered, flags clear on the cycle after the read strobe
`include "sif_regs.svh"
`default_nettype none
// Function
// - twelve low-limit flags in word 0x008 bits 0..11, set on low threshold pass.
// - twelve high-limit flags in word 0x009 bits 0..11, set on high threshold pass.
// - twelve completion flags in word 0x00a bits 0..11, set per finished conversion.
// - bit 12 of completion word sets when the general-purpose pin level changes.
// - reading a word clears its flags, except limits still exceeded and events set in the read cycle.
// - completion enable bit per stage gates completion onto active-low interrupt.
// - enable bit 12 gates pin level change onto the interrupt.
module sif_stage_flags (
	input wire logic CORE_CLK_IN,
	input wire logic RST_N_IN,
	input wire logic [`SIF_ADDR_W-1:0] REG_ADDR_IN,
	input wire logic REG_RD_IN,
	input wire logic REG_WR_IN,
	input wire logic [15:0] REG_WDATA_IN,
	output logic [15:0] REG_RDATA_OUT,
	input wire logic [11:0] STAGE_LOW_EXCEED_IN,
	input wire logic [11:0] STAGE_HIGH_EXCEED_IN,
	input wire logic [11:0] STAGE_DONE_IN,
	input wire logic GPIO_PIN_IN,
	output logic INT_N_OUT
);
	// flag words
	sif_pkg::sif_stage_type low_r;
	sif_pkg::sif_stage_type high_r;
	sif_pkg::sif_stage_type done_r;
	sif_pkg::sif_stage_type low_nxt;
	sif_pkg::sif_stage_type high_nxt;
	sif_pkg::sif_stage_type done_nxt;
	logic gpio_flag_r;
	logic gpio_flag_nxt;
	logic [12:0] done_en_r;
	sif_pkg::sif_word_type rdata_r;
	sif_pkg::sif_word_type rdata_nxt;
	// pin synchroniser and last agreed level
	logic gpio_s1_r;
	logic gpio_s2_r;
	logic gpio_s3_r;
	logic gpio_lvl_r;
	logic gpio_prev_seen_r;
	logic int_n_r;

	// one compare per word keeps read and write decode in step
	function automatic logic hit_word(input logic [`SIF_ADDR_W-1:0] addr,
		input logic [`SIF_ADDR_W-1:0] ofs);
		hit_word = (addr == ofs);
	endfunction : hit_word

	// clear on read, keep what is still asserted; the set term wins over the clear
	function automatic sif_pkg::sif_stage_type next_flags(input sif_pkg::sif_stage_type cur,
		input logic clr,
		input sif_pkg::sif_stage_type keep,
		input sif_pkg::sif_stage_type set);
		next_flags = (clr ? keep : cur) | set;
	endfunction : next_flags

	wire rd_low = REG_RD_IN && hit_word(REG_ADDR_IN, `SIF_LOW_FLAGS_OFS);
	wire rd_high = REG_RD_IN && hit_word(REG_ADDR_IN, `SIF_HIGH_FLAGS_OFS);
	wire rd_done = REG_RD_IN && hit_word(REG_ADDR_IN, `SIF_DONE_FLAGS_OFS);
	wire rd_en = REG_RD_IN && hit_word(REG_ADDR_IN, `SIF_DONE_EN_OFS);
	wire wr_en = REG_WR_IN && hit_word(REG_ADDR_IN, `SIF_DONE_EN_OFS);
	// a change counts once the second and third stages agree, glitches are filtered
	wire gpio_agree = (gpio_s2_r == gpio_s3_r);
	// no change before the first agreement after reset, so no false edge
	wire gpio_change = gpio_agree && gpio_prev_seen_r && (gpio_s3_r != gpio_lvl_r);
	// set wins over clear; limits still exceeded survive the read
	assign low_nxt = next_flags(low_r, rd_low, STAGE_LOW_EXCEED_IN,
		STAGE_LOW_EXCEED_IN);
	assign high_nxt = next_flags(high_r, rd_high, STAGE_HIGH_EXCEED_IN,
		STAGE_HIGH_EXCEED_IN);
	assign done_nxt = next_flags(done_r, rd_done, 12'h000, STAGE_DONE_IN);
	assign gpio_flag_nxt = (rd_done ? 1'b0 : gpio_flag_r) | gpio_change;
	// limit flags do not reach the interrupt here, only completion and pin sources
	wire irq_any = (|(done_nxt & done_en_r[11:0])) ||
		(gpio_flag_nxt && done_en_r[`SIF_GPIO_BIT]);
	// upper bits read as zero
	assign rdata_nxt = rd_low ? {4'h0, low_r} :
		rd_high ? {4'h0, high_r} :
		rd_done ? {3'h0, gpio_flag_r, done_r} :
		rd_en ? {3'h0, done_en_r} : 16'h0000;
	always_ff @(posedge CORE_CLK_IN) begin
		if (!RST_N_IN) begin
			low_r <= 12'h000;
			high_r <= 12'h000;
			done_r <= 12'h000;
			gpio_flag_r <= 1'b0;
			done_en_r <= `SIF_EN_RST;
			rdata_r <= `SIF_FLAGS_RST;
			int_n_r <= 1'b1;
			gpio_prev_seen_r <= 1'b0;
			gpio_lvl_r <= 1'b0;
		end else begin
			low_r <= low_nxt;
			high_r <= high_nxt;
			done_r <= done_nxt;
			gpio_flag_r <= gpio_flag_nxt;
			rdata_r <= rdata_nxt;
			if (wr_en) begin
				done_en_r <= REG_WDATA_IN[12:0];
			end
			int_n_r <= !irq_any;
			if (gpio_agree) begin
				gpio_lvl_r <= gpio_s3_r;
				gpio_prev_seen_r <= 1'b1;
			end
		end
	end
	always_ff @(posedge CORE_CLK_IN) begin
		gpio_s1_r <= GPIO_PIN_IN;
		gpio_s2_r <= gpio_s1_r;
		gpio_s3_r <= gpio_s2_r;
	end
	assign REG_RDATA_OUT = rdata_r;
	assign INT_N_OUT = int_n_r;


	// setting
	AST_DONE_SETS: assert property (
		@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
		STAGE_DONE_IN[0] |=> done_r[0])
		else $error("done flag not set");
	AST_LOW_SETS: assert property (
		@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
		STAGE_LOW_EXCEED_IN[5] |=> low_r[5])
		else $error("low flag not set");
	AST_HIGH_SETS: assert property (
		@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
		STAGE_HIGH_EXCEED_IN[11] |=> high_r[11])
		else $error("high flag not set");
	AST_GPIO_FLAG: assert property (
		@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
		gpio_change |=> gpio_flag_r)
		else $error("pin change lost");
	AST_GPIO_QUIET: assert property (
		@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
		!gpio_prev_seen_r |=> !gpio_flag_r)
		else $error("pin flag set before first agreement");

	// clearing on read
	AST_DONE_CLEAR: assert property (
		@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
		rd_done && !STAGE_DONE_IN[3] |=> !done_r[3])
		else $error("done not cleared");
	AST_LOW_CLEAR: assert property (
		@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
		rd_low && !STAGE_LOW_EXCEED_IN[0] |=> !low_r[0])
		else $error("low not cleared");
	AST_HIGH_CLEAR: assert property (
		@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
		rd_high && !STAGE_HIGH_EXCEED_IN[6] |=> !high_r[6])
		else $error("high not cleared");
	AST_GPIO_CLEAR: assert property (
		@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
		rd_done && !gpio_change |=> !gpio_flag_r)
		else $error("pin flag not cleared");
	AST_LOW_HOLD: assert property (
		@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
		rd_low && STAGE_LOW_EXCEED_IN[2] |=> low_r[2])
		else $error("low lost on read");
	AST_HIGH_HOLD: assert property (
		@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
		rd_high && STAGE_HIGH_EXCEED_IN[4] |=> high_r[4])
		else $error("high lost on read");
	AST_DONE_HOLD: assert property (
		@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
		rd_done && STAGE_DONE_IN[1] |=> done_r[1])
		else $error("done event lost on read");

	// read data
	AST_UPPER_ZERO: assert property (
		@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
		$past(rd_low) |-> REG_RDATA_OUT[15:12] == 4'h0)
		else $error("upper bits set");
	AST_UPPER_ZERO_DONE: assert property (
		@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
		rd_done |=> REG_RDATA_OUT[15:13] == 3'h0)
		else $error("upper completion bits set");
	AST_READ_LOW_DATA: assert property (
		@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
		rd_low |=> REG_RDATA_OUT[11:0] == $past(low_r))
		else $error("low word read wrong");
	AST_READ_HIGH_DATA: assert property (
		@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
		rd_high |=> REG_RDATA_OUT[11:0] == $past(high_r))
		else $error("high word read wrong");
	AST_READ_DONE_DATA: assert property (
		@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
		rd_done |=> REG_RDATA_OUT[11:0] == $past(done_r))
		else $error("completion word read wrong");
	AST_RDATA_IDLE: assert property (
		@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
		!REG_RD_IN |=> REG_RDATA_OUT == 16'h0000)
		else $error("read data without a read");

	// interrupt output
	AST_INT_DONE: assert property (
		@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
		STAGE_DONE_IN[1] && done_en_r[1] |=> !INT_N_OUT)
		else $error("no interrupt");
	AST_INT_PIN: assert property (
		@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
		gpio_change && done_en_r[12] |=> !INT_N_OUT)
		else $error("no interrupt on pin change");
	AST_INT_OFF: assert property (
		@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
		done_en_r == 13'h0000 |=> INT_N_OUT)
		else $error("interrupt while disabled");
endmodule : sif_stage_flags
`default_nettype wire

// >>> tb/sif_host_model.sv
// Purpose: host model on the register port
// Assumes: the host only ever writes the enable word
// Notes: unused bits are kept low, so a device that mishandles them goes unseen here
`default_nettype none
module sif_host_model (
	input wire logic [15:0] wdata_in,
	output logic [15:0] wdata_out
);
	timeunit 1ns / 1ns;
	assign wdata_out = {3'h0, wdata_in[12:0]};
endmodule : sif_host_model
`default_nettype wire

// >>> tb/tb_top.sv
// Purpose: self-checking bench of the stage flag block
// Assumes: limit inputs are levels and stay held between accesses
// Notes: row = {int_n, write, addr, low, high, done, rdata}; pin case runs after the rows, then a reset check
`default_nettype none
module tb_top;
	timeunit 1ns / 1ns;
	logic clk = 0, rst_n = 0, rd = 0, wr = 0, gpio = 0, int_n;
	logic [9:0] addr = 0;
	logic [11:0] lo = 0, hi = 0, dn = 0;
	logic [15:0] wdm, rdata;
	int num_errors = 0, check_count = 0;
	logic [63:0] rows [15] = '{64'h807_000000000_0000, 64'h808_000000000_0000,
		64'h80a_000000000_0000, 64'h80b_8017fefff_0000, 64'h808_000000000_0801,
		64'h809_000000000_07fe, 64'h80a_004000000_0fff, 64'h808_004000000_0004,
		64'h808_000000000_0004, 64'h80a_000000002_0000, 64'h80a_000000000_0002,
		64'hc07_000000000_0000, 64'h807_000000000_1008, 64'h00b_000000008_0000,
		64'h80a_000000000_0008};
	always #10 clk = ~clk;
	sif_host_model host (.wdata_in(16'hf008), .wdata_out(wdm));
	sif_stage_flags dut (.CORE_CLK_IN(clk), .RST_N_IN(rst_n), .REG_RD_IN(rd), .REG_WR_IN(wr),
		.REG_ADDR_IN(addr), .REG_WDATA_IN(wdm), .REG_RDATA_OUT(rdata), .INT_N_OUT(int_n),
		.STAGE_LOW_EXCEED_IN(lo), .STAGE_HIGH_EXCEED_IN(hi), .STAGE_DONE_IN(dn), .GPIO_PIN_IN(gpio));
	task automatic chk(string n, logic [16:0] seen, logic [16:0] exp);
		check_count++;
		num_errors += int'(seen !== exp);
		if (seen !== exp) $display("MISMATCH %s expected %h seen %h", n, exp, seen);
	endtask : chk
	task automatic op(logic [63:0] r);
		@(posedge clk);
		{rd, wr, addr, lo, hi, dn} <= {~r[62], r[62:16]};
		@(posedge clk);
		{rd, wr, dn} <= '0;
		#1 chk("int_n rdata", {int_n, rdata}, {r[63], r[15:0]});
	endtask : op
	task automatic print_verdict();
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : print_verdict
	initial begin
		repeat (5) @(posedge clk);
		rst_n <= 1;
		foreach (rows[i]) op(rows[i]);
		@(posedge clk) gpio <= 1;
		repeat (8) @(posedge clk);
		op(64'h007_000000000_1008);
		op(64'h80a_000000000_1000);
		op(64'h00b_000000008_0000);
		@(posedge clk) rst_n <= 0;
		repeat (2) @(posedge clk);
		#1 chk("reset int_n rdata", {int_n, rdata}, 17'h10000);
		@(posedge clk) rst_n <= 1;
		op(64'h80a_000000000_0000);
		op(64'h807_000000000_0000);
		print_verdict();
	end
	initial #10000 begin
		num_errors++;
		print_verdict();
	end
endmodule : tb_top
`default_nettype wire
